// ===== mbhp_asserts.sv
// Interface checks for the multiplexed bus host port
`timescale 1ns/1ps
module mbhp_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bus pins
  input wire logic address_strobe_n,
  input wire logic data_strobe_n,
  input wire logic read_write,
  input wire logic interrupt_acknowledge_n,
  input wire logic priority_chain_in,
  input wire logic priority_chain_out,
  input wire logic bus_host_oe,
  input wire logic bus_dev_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Drive only after the synchronised strobe, release after it rises
  a_read_drive_late: assert property (
    $fell(data_strobe_n) && read_write && interrupt_acknowledge_n
    |-> !bus_dev_oe ##[1:6] bus_dev_oe) else $error("read data not driven");
  a_release_bus: assert property (
    $rose(data_strobe_n) |-> ##[1:6] !bus_dev_oe) else $error("bus not released");
  a_write_no_drive: assert property (
    $fell(data_strobe_n) && !read_write && interrupt_acknowledge_n
    |=> (bus_host_oe && !bus_dev_oe)[*6]) else $error("write data clash");
  a_ds_recovery: assert property (
    $fell(data_strobe_n) |=> (!$fell(data_strobe_n))[*3]) else $error("recovery too short");
  a_ack_settle: assert property (
    $rose(address_strobe_n) && !interrupt_acknowledge_n |-> data_strobe_n[*4])
    else $error("chain settle too short");
  a_addr_phase: assert property (
    !address_strobe_n |-> bus_host_oe && data_strobe_n) else $error("address not driven");
  a_ack_unclaimed: assert property (
    $fell(data_strobe_n) && !interrupt_acknowledge_n && !priority_chain_in
    |-> (!bus_dev_oe)[*6]) else $error("ack claimed with chain low");
  a_chain_out_gated: assert property (
    (!priority_chain_in)[*4] |-> !priority_chain_out) else $error("chain out without chain in");
  a_ack_host_quiet: assert property (
    $fell(data_strobe_n) && !interrupt_acknowledge_n |-> (!bus_host_oe)[*6])
    else $error("host drives during ack");
  // Main scenarios reached
  c_read: cover property ($fell(data_strobe_n) && read_write && interrupt_acknowledge_n);
  c_write: cover property ($fell(data_strobe_n) && !read_write && interrupt_acknowledge_n);
  c_ack: cover property ($fell(data_strobe_n) && !interrupt_acknowledge_n ##[1:6] bus_dev_oe);
endmodule : mbhp_asserts

// ===== mbhp_consts.svh
// Timing counts and field constants for the multiplexed bus host port
`ifndef MBHP_CONSTS_SVH
`define MBHP_CONSTS_SVH
`define MBHP_CLK_PERIOD_NS     10
`define MBHP_RECOVERY_NS       40
`define MBHP_RECOVERY_CYC      ((`MBHP_RECOVERY_NS + `MBHP_CLK_PERIOD_NS - 1) / `MBHP_CLK_PERIOD_NS)
`define MBHP_CHAIN_SETTLE_NS   50
`define MBHP_CHAIN_SETTLE_CYC  ((`MBHP_CHAIN_SETTLE_NS + `MBHP_CLK_PERIOD_NS - 1) / `MBHP_CLK_PERIOD_NS)
`define MBHP_STROBE_LOW_CYC    8
`define MBHP_ADDR_SETUP_CYC    2
`define MBHP_VECTOR_RESET      8'h00
`endif

// ===== mbhp_device.sv
// Device end of the multiplexed address/data bus port
//
// Functional notes
// RULE_01: Strobes resynchronised to clock, three stages
// RULE_02: Host waits recovery between accesses here
// RULE_03: Recovery counted data strobe fall to fall
// RULE_04: Address strobe rise latches address, selects, acknowledge; the code latches only the low select, the high select is read live
// RULE_05: Read needs read select and high select
// RULE_06: Drive bus only while data strobe low
// RULE_07: Write needs write select and high select
// RULE_08: Write data taken during data strobe low
// RULE_09: Acknowledge ignores address and chip selects
// RULE_10: Host lets daisy chain settle before strobe
// RULE_11: Claim acknowledge when pending and chain high
// RULE_12: Claimed acknowledge drives vector, sets in-service
`include "mbhp_consts.svh"
`timescale 1ns/1ps
module mbhp_device #(
  parameter logic [7:0] VECTOR = `MBHP_VECTOR_RESET
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Bus pins
  mbhp_if.device          bus,
  // Register side
  input  wire logic       irq_pending_i,
  input  wire logic       vector_enable_i,
  input  wire logic [7:0] read_data_i,
  output logic      [7:0] reg_addr_o,
  output logic            read_strobe_o,
  output logic            write_strobe_o,
  output logic      [7:0] write_data_o,
  output logic            in_service_o
);
  // Three-stage synchronisers: addr strobe, data strobe, chain in
  logic [2:0] as_sync, ds_sync, iei_sync;
  logic [2:0] next_as_sync, next_ds_sync, next_iei_sync;
  logic       as_state, ds_state;
  logic       next_as_state, next_ds_state;
  logic [7:0] addr_lat, next_addr_lat;
  logic       cs0_lat, next_cs0_lat;
  logic       ack_lat, next_ack_lat;
  mbhp_pkg::mbhp_cyc_e cyc, next_cyc;
  logic       drive, next_drive;
  logic [7:0] dout, next_dout;
  logic [7:0] reg_addr, next_reg_addr;
  logic       rd_stb, next_rd_stb;
  logic       wr_stb, next_wr_stb;
  logic [7:0] wdata, next_wdata;
  logic       in_srv, next_in_srv;
  logic       as_rise, ds_fall, ds_rise;
  // Pin samples delayed in step with the strobe synchronisers
  logic [9:0] pin_s0, next_pin_s0;
  logic [9:0] pin_s1, next_pin_s1;
  logic [9:0] pin_s2, next_pin_s2;
  logic [9:0] pin_hold, next_pin_hold;

  // Filtered edges: stage 2 and 3 must agree before a change counts
  always_comb begin
    next_as_sync  = {as_sync[1:0], bus.address_strobe_n};  // RULE_01
    next_ds_sync  = {ds_sync[1:0], bus.data_strobe_n};     // RULE_01
    next_iei_sync = {iei_sync[1:0], bus.priority_chain_in};
    next_as_state = (as_sync[2] == as_sync[1]) ? as_sync[2] : as_state;
    next_ds_state = (ds_sync[2] == ds_sync[1]) ? ds_sync[2] : ds_state;
    as_rise = !as_state && next_as_state;
    ds_fall = ds_state && !next_ds_state;
    ds_rise = !ds_state && next_ds_state;
  end

  // Bus, low select and acknowledge sampled beside the strobes. The hold
  // keeps the last sample taken while either synchronised strobe was low:
  // by the time a filtered edge is seen the host has moved the pins on,
  // so the raw pins at that point are no longer the cycle's values
  always_comb begin
    next_pin_s0   = {bus.interrupt_acknowledge_n, bus.chip_select_low_active,
                     bus.muxed_address_data_bus};
    next_pin_s1   = pin_s0;
    next_pin_s2   = pin_s1;
    next_pin_hold = (!as_sync[2] || !ds_sync[2]) ? pin_s2 : pin_hold;  // RULE_04 RULE_08
  end

  // Cycle decode and data path
  // Direction and high select are read live; the host holds them all cycle
  always_comb begin
    next_addr_lat = addr_lat;
    next_cs0_lat  = cs0_lat;
    next_ack_lat  = ack_lat;
    next_cyc      = cyc;
    next_drive    = drive;
    next_dout     = dout;
    next_reg_addr = reg_addr;
    next_rd_stb   = 1'b0;
    next_wr_stb   = 1'b0;
    next_wdata    = wdata;
    next_in_srv   = in_srv;
    // The filtered rise lags the pin by the synchroniser depth, so the
    // address, low select and acknowledge come from the sample held
    // while the synchronised address strobe was still low
    if (as_rise) begin
      next_addr_lat = pin_hold[7:0];                  // RULE_04
      next_cs0_lat  = pin_hold[8];                    // RULE_04
      next_ack_lat  = pin_hold[9];                    // RULE_04
      next_cyc      = mbhp_pkg::MBHP_CYC_NONE;
      next_in_srv   = 1'b0;
    end
    if (ds_fall) begin
      if (!ack_lat) begin
        // Address, selects and direction are ignored here
        if (irq_pending_i && iei_sync[2]) begin      // RULE_09 RULE_11
          next_cyc = mbhp_pkg::MBHP_CYC_ACK;
          if (vector_enable_i) begin                 // RULE_12
            next_drive  = 1'b1;
            next_dout   = VECTOR;
            next_in_srv = 1'b1;
          end
        end
      end else if (!cs0_lat && bus.chip_select_high_active) begin
        if (bus.read_write) begin
          next_cyc      = mbhp_pkg::MBHP_CYC_READ;   // RULE_05
          next_drive    = 1'b1;                      // RULE_06
          next_dout     = read_data_i;
          next_rd_stb   = 1'b1;
          next_reg_addr = addr_lat;
        end else begin
          next_cyc = mbhp_pkg::MBHP_CYC_WRITE;       // RULE_07
        end
      end
    end
    // Write data sampled at the close of the low phase, taken from the
    // last sample held while the synchronised data strobe was low
    if (ds_rise) begin
      if (cyc == mbhp_pkg::MBHP_CYC_WRITE) begin
        next_wdata    = pin_hold[7:0];               // RULE_08
        next_wr_stb   = 1'b1;
        next_reg_addr = addr_lat;
      end
      next_drive = 1'b0;                             // RULE_06
      next_cyc   = mbhp_pkg::MBHP_CYC_NONE;
    end
  end

  // Synchroniser and pin delay registers
  // Strobes and pin samples rest at their idle high levels out of reset; the chain in synchroniser starts low
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      as_sync  <= 3'h7;
      ds_sync  <= 3'h7;
      iei_sync <= 3'h0;
      as_state <= 1'b1;
      ds_state <= 1'b1;
      pin_s0   <= 10'h3FF;
      pin_s1   <= 10'h3FF;
      pin_s2   <= 10'h3FF;
      pin_hold <= 10'h3FF;
    end else begin
      as_sync  <= next_as_sync;
      ds_sync  <= next_ds_sync;
      iei_sync <= next_iei_sync;
      as_state <= next_as_state;
      ds_state <= next_ds_state;
      pin_s0   <= next_pin_s0;
      pin_s1   <= next_pin_s1;
      pin_s2   <= next_pin_s2;
      pin_hold <= next_pin_hold;
    end
  end

  // Cycle state registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      addr_lat <= 8'h00;
      cs0_lat  <= 1'b1;
      ack_lat  <= 1'b1;
      cyc      <= mbhp_pkg::MBHP_CYC_NONE;
      drive    <= 1'b0;
      dout     <= 8'h00;
      reg_addr <= 8'h00;
      rd_stb   <= 1'b0;
      wr_stb   <= 1'b0;
      wdata    <= 8'h00;
      in_srv   <= 1'b0;
    end else begin
      addr_lat <= next_addr_lat;
      cs0_lat  <= next_cs0_lat;
      ack_lat  <= next_ack_lat;
      cyc      <= next_cyc;
      drive    <= next_drive;
      dout     <= next_dout;
      reg_addr <= next_reg_addr;
      rd_stb   <= next_rd_stb;
      wr_stb   <= next_wr_stb;
      wdata    <= next_wdata;
      in_srv   <= next_in_srv;
    end
  end

  // Outputs; chain out passes on only when nothing is pending here
  // Register side strobes are one clock wide
  assign bus.bus_dev_o          = dout;
  assign bus.bus_dev_oe         = drive;
  assign bus.priority_chain_out = iei_sync[2] && !irq_pending_i && !in_srv;
  assign reg_addr_o             = reg_addr;
  assign read_strobe_o          = rd_stb;
  assign write_strobe_o         = wr_stb;
  assign write_data_o           = wdata;
  assign in_service_o           = in_srv;
endmodule : mbhp_device

// ===== mbhp_host.sv
// Host end of the multiplexed address/data bus port
`include "mbhp_consts.svh"
`timescale 1ns/1ps
module mbhp_host #(
  parameter int RECOVERY_CYC = `MBHP_RECOVERY_CYC,
  parameter int SETTLE_CYC   = `MBHP_CHAIN_SETTLE_CYC,
  parameter int LOW_CYC      = `MBHP_STROBE_LOW_CYC
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Bus pins
  mbhp_if.host            bus,
  // Command port
  input  wire logic       req_i,
  input  wire mbhp_pkg::mbhp_cyc_e kind_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic            ready_o,
  output logic            done_o,
  output logic      [7:0] rdata_o
);
  typedef enum logic [2:0] {MBHP_IDLE, MBHP_ADDR, MBHP_GAP, MBHP_DATA, MBHP_END} mbhp_st_e;
  mbhp_st_e st, next_st;
  logic [15:0] cnt, next_cnt;
  logic [15:0] rec, next_rec;
  mbhp_pkg::mbhp_cyc_e kind, next_kind;
  logic [7:0] addr, next_addr, wd, next_wd, rd, next_rd;
  logic       done, next_done;

  // Transaction sequencer
  always_comb begin
    next_st   = st;
    next_cnt  = (cnt != 16'h0000) ? cnt - 16'h0001 : cnt;
    next_rec  = (rec != 16'h0000) ? rec - 16'h0001 : rec;
    next_kind = kind;
    next_addr = addr;
    next_wd   = wd;
    next_rd   = rd;
    next_done = 1'b0;
    unique case (st)
      MBHP_IDLE: begin
        if (req_i && rec == 16'h0000) begin                // RULE_02
          next_st   = MBHP_ADDR;
          next_kind = kind_i;
          next_addr = addr_i;
          next_wd   = wdata_i;
          next_cnt  = 16'(`MBHP_ADDR_SETUP_CYC);
        end
      end
      MBHP_ADDR: if (cnt == 16'h0000) begin
        next_st  = MBHP_GAP;
        next_cnt = (kind == mbhp_pkg::MBHP_CYC_ACK) ? 16'(SETTLE_CYC) : 16'h0001; // RULE_10
      end
      MBHP_GAP: if (cnt == 16'h0000) begin
        next_st  = MBHP_DATA;
        next_cnt = 16'(LOW_CYC);
        next_rec = 16'(RECOVERY_CYC);                    // RULE_03
      end
      MBHP_DATA: if (cnt == 16'h0000) begin
        next_st   = MBHP_END;
        next_rd   = bus.muxed_address_data_bus;
        next_done = 1'b1;
      end
      MBHP_END: next_st = MBHP_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st   <= MBHP_IDLE;
      cnt  <= 16'h0000;
      rec  <= 16'h0000;
      kind <= mbhp_pkg::MBHP_CYC_NONE;
      addr <= 8'h00;
      wd   <= 8'h00;
      rd   <= 8'h00;
      done <= 1'b0;
    end else begin
      st   <= next_st;
      cnt  <= next_cnt;
      rec  <= next_rec;
      kind <= next_kind;
      addr <= next_addr;
      wd   <= next_wd;
      rd   <= next_rd;
      done <= next_done;
    end
  end

  // Pin drive from state
  assign bus.address_strobe_n        = (st != MBHP_ADDR);
  assign bus.data_strobe_n           = (st != MBHP_DATA);
  assign bus.read_write              = (kind != mbhp_pkg::MBHP_CYC_WRITE); // RULE_05 RULE_07
  assign bus.chip_select_high_active = (st != MBHP_IDLE);                   // RULE_05 RULE_07
  assign bus.chip_select_low_active  = 1'b0;
  assign bus.interrupt_acknowledge_n = (kind != mbhp_pkg::MBHP_CYC_ACK) || (st == MBHP_IDLE);
  assign bus.bus_host_o  = (st == MBHP_ADDR) ? addr : wd;
  assign bus.bus_host_oe = (st == MBHP_ADDR) || (kind == mbhp_pkg::MBHP_CYC_WRITE &&
                           (st == MBHP_GAP || st == MBHP_DATA || st == MBHP_END));
  assign ready_o = (st == MBHP_IDLE) && (rec == 16'h0000);
  assign done_o  = done;
  assign rdata_o = rd;
endmodule : mbhp_host

// ===== mbhp_if.sv
// Pin bundle between the host and the multiplexed address/data bus port
`timescale 1ns/1ps
interface mbhp_if;
  logic       address_strobe_n;
  logic       data_strobe_n;
  logic       read_write;
  logic       chip_select_low_active;
  logic       chip_select_high_active;
  logic       interrupt_acknowledge_n;
  logic       priority_chain_in;
  logic       priority_chain_out;
  logic [7:0] bus_host_o;
  logic       bus_host_oe;
  logic [7:0] bus_dev_o;
  logic       bus_dev_oe;
  logic [7:0] muxed_address_data_bus;

  // Resolved bus level: the device wins over the host when both enable, else all ones as pull-up
  assign muxed_address_data_bus = bus_dev_oe  ? bus_dev_o  :
                                  bus_host_oe ? bus_host_o : 8'hFF;

  modport device (
    input  address_strobe_n, data_strobe_n, read_write, chip_select_low_active,
    input  chip_select_high_active, interrupt_acknowledge_n, priority_chain_in,
    input  muxed_address_data_bus,
    output priority_chain_out, bus_dev_o, bus_dev_oe
  );
  modport host (
    output address_strobe_n, data_strobe_n, read_write, chip_select_low_active,
    output chip_select_high_active, interrupt_acknowledge_n, bus_host_o, bus_host_oe,
    input  muxed_address_data_bus
  );
endinterface : mbhp_if

// ===== mbhp_pkg.sv
// Types shared by both ends of the multiplexed bus host port
package mbhp_pkg;
  typedef enum logic [1:0] {
    MBHP_CYC_NONE,
    MBHP_CYC_READ,
    MBHP_CYC_WRITE,
    MBHP_CYC_ACK
  } mbhp_cyc_e;
endpackage : mbhp_pkg

// ===== testbench.sv
// Self-checking bench joining the host and device ends of the bus port
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] VEC = 8'h5C;
  logic                clk_i = 1'b0;
  logic                rst_n_i = 1'b0;
  logic                req_i = 1'b0;
  mbhp_pkg::mbhp_cyc_e kind_i = mbhp_pkg::MBHP_CYC_NONE;
  logic [7:0]          addr_i = 8'h00;
  logic [7:0]          wdata_i = 8'h00;
  logic                irq_pending_i = 1'b0;
  logic                vector_enable_i = 1'b1;
  logic [7:0]          read_data_i = 8'h00;
  logic                ready_o, done_o, read_strobe_o, write_strobe_o, in_service_o;
  logic [7:0]          rdata_o, reg_addr_o, write_data_o, a, d;
  logic [15:0]         wq[$];
  logic [7:0]          rq[$];
  logic [15:0]         e;
  int                  n_errors = 0;
  int                  comparisons = 0;
  int unsigned         seed = 14;
  mbhp_if bus ();
  mbhp_host u_mbhp_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus), .req_i(req_i),
    .kind_i(kind_i), .addr_i(addr_i), .wdata_i(wdata_i), .ready_o(ready_o),
    .done_o(done_o), .rdata_o(rdata_o));
  mbhp_device #(.VECTOR(VEC)) u_mbhp_device (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus),
    .irq_pending_i(irq_pending_i), .vector_enable_i(vector_enable_i),
    .read_data_i(read_data_i), .reg_addr_o(reg_addr_o), .read_strobe_o(read_strobe_o),
    .write_strobe_o(write_strobe_o), .write_data_o(write_data_o),
    .in_service_o(in_service_o));
  mbhp_asserts u_mbhp_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .address_strobe_n(bus.address_strobe_n), .data_strobe_n(bus.data_strobe_n),
    .read_write(bus.read_write), .interrupt_acknowledge_n(bus.interrupt_acknowledge_n),
    .priority_chain_in(bus.priority_chain_in), .priority_chain_out(bus.priority_chain_out),
    .bus_host_oe(bus.bus_host_oe), .bus_dev_oe(bus.bus_dev_oe));
  // Clock
  always #5 clk_i = ~clk_i;
  // Xorshift source
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  // Comparisons
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %b", $time, what, got);
    end
  endtask : chk_bit
  // Verdict
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  // One host transaction, bounded waits for take and completion
  task automatic run(input mbhp_pkg::mbhp_cyc_e k, input logic [7:0] ad, wd, rd);
    int n;
    @(negedge clk_i);
    req_i = 1'b1;
    kind_i = k;
    addr_i = ad;
    wdata_i = wd;
    read_data_i = rd;
    n = 0;
    while (ready_o !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
    req_i = 1'b0;
    while (done_o !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 100) begin
      n_errors++;
      $display("unexpected at %0t: transaction hung", $time);
      wrap_up();
    end
  endtask : run
  // Register side strobes against the expected queues, looked at mid-cycle
  always @(negedge clk_i) begin
    if (write_strobe_o === 1'b1) begin
      e = (wq.size() > 0) ? wq.pop_front() : 16'hXXXX;
      chk_byte(reg_addr_o, e[15:8], "write address");
      chk_byte(write_data_o, e[7:0], "write data");
    end
    if (read_strobe_o === 1'b1) begin
      chk_byte(reg_addr_o, (rq.size() > 0) ? rq.pop_front() : 8'hXX, "read address");
    end
  end
  // Main sequence
  initial begin
    bus.priority_chain_in = 1'b1;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) begin
      a = rnd();
      d = rnd();
      wq.push_back({a, d});
      run(mbhp_pkg::MBHP_CYC_WRITE, a, d, 8'h00);
    end
    $display("test write done");
    repeat (4) begin
      a = rnd();
      d = rnd();
      rq.push_back(a);
      run(mbhp_pkg::MBHP_CYC_READ, a, 8'h00, d);
      chk_byte(rdata_o, d, "read data");
    end
    $display("test read done");
    for (int i = 4; i >= 0; i--) begin
      @(negedge clk_i);
      irq_pending_i = (i == 4) | i[1];
      bus.priority_chain_in = (i == 4) | i[0];
      vector_enable_i = (i != 4);
      run(mbhp_pkg::MBHP_CYC_ACK, rnd(), rnd(), rnd());
      chk_byte(rdata_o, (i == 3) ? VEC : 8'hFF, "ack data");
      if (i < 4) chk_bit(in_service_o, i == 3, "in service");
      chk_bit(bus.priority_chain_out, bus.priority_chain_in & !irq_pending_i, "chain");
    end
    chk_byte(8'(wq.size() + rq.size()), 8'h00, "stray strobes");
    $display("test ack done");
    wrap_up();
  end
endmodule : testbench
